// file: utf_defs.vh
// constants used by the uart event block; its fifo uses none of them
// assumes a 32-bit classic wishbone slave and one 200 MHz clock
`ifndef UTF_DEFS_VH
`define UTF_DEFS_VH
// register byte offsets
`define UTF_ADR_DATA 4'h0
`define UTF_ADR_CTRL 4'h4
`define UTF_ADR_STAT 4'h8
`define UTF_ADR_DIV 4'hc
// control field positions
`define UTF_CTL_FEN 0
`define UTF_CTL_TRG_LO 1
`define UTF_CTL_TRG_HI 2
`define UTF_CTL_PEN 3
// status field positions
`define UTF_ST_THRE 0
`define UTF_ST_RXRDY 1
`define UTF_ST_ERR 2
`define UTF_ST_OVR 3
`define UTF_ST_TXFULL 4
`define UTF_ST_CNT_LO 8
`define UTF_ST_CNT_HI 12
// data read field positions
`define UTF_RD_FERR 8
`define UTF_RD_PERR 9
// reset values
`define UTF_CTL_RST 4'h0
`define UTF_DIV_RST 16'h006c
// receive trigger levels in bytes
`define UTF_TRG_00 5'h01
`define UTF_TRG_01 5'h04
`define UTF_TRG_10 5'h08
`define UTF_TRG_11 5'h0e
// oversampling: last of 16 baud clock ticks per bit, mid-bit sample point
`define UTF_OS_LAST 4'hf
`define UTF_OS_MID 4'h7
// frame bit counts with and without parity
`define UTF_BITS_PAR 4'hb
`define UTF_BITS_NOPAR 4'ha
// bit index just past the last data bit of a frame
`define UTF_DATA_END 4'h9
`endif

// file: utf_fifo.v
// synchronous fifo with valid/ready on both sides and a fill count
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module utf_fifo #(
    parameter DW = 10,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i, // system clock
    input wire rst_i, // synchronous reset
    input wire in_valid_i, // write request
    output wire in_ready_o, // space available
    input wire [DW-1:0] in_data_i, // write data
    output wire out_valid_o, // data available
    input wire out_ready_i, // read acknowledge
    output wire [DW-1:0] out_data_o, // head data
    output wire [AW:0] count_o // words held
);
    reg [DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ff;
    reg [AW-1:0] rd_ff;
    reg [AW:0] cnt_ff;
    wire do_wr;
    wire do_rd;

    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
                ptr_inc = {AW{1'b0}};
            else
                ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
    assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ff];
    assign count_o = cnt_ff;
    assign do_wr = in_valid_i & in_ready_o;
    assign do_rd = out_ready_i & out_valid_o;

    always @(posedge clk_i) begin
        if (do_wr)
            mem[wr_ff] <= in_data_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ff <= {AW{1'b0}};
            rd_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr)
                wr_ff <= ptr_inc(wr_ff);
            if (do_rd)
                rd_ff <= ptr_inc(rd_ff);
            if (do_wr & ~do_rd)
                cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
            else if (do_rd & ~do_wr)
                cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
        end
    end
endmodule

// file: utf_remote.sv
// remote serial partner: sends frames on rx, collects frames from tx
// assumes BIT clock cycles per bit, even parity, one stop bit
`timescale 1ns/1ps
module utf_remote #(
    parameter BIT = 32
) (
    input wire clk_i, // clock
    input wire line_i, // block serial out
    output logic line_o // block serial in
);
    logic [7:0] got[$];
    logic [7:0] sh;
    integer i;
    initial line_o = 1'b1;
    task send(input [7:0] d, input par, input bad_par, input bad_stop);
        logic [10:0] f;
        integer k;
        begin
            f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
            for (k = 0; k < 11; k++) begin
                if (k != 9 || par) begin
                    @(posedge clk_i);
                    line_o <= f[k];
                    repeat (BIT - 1) @(posedge clk_i);
                end
            end
            @(posedge clk_i);
            line_o <= 1'b1;
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    // mid-bit sampling of transmitted frames
    initial begin
        forever begin
            @(negedge line_i);
            repeat (BIT / 2) @(posedge clk_i);
            for (i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                sh[i] = line_i;
            end
            repeat (BIT) @(posedge clk_i);
            got.push_back(sh);
        end
    end
endmodule

// file: utf_uart.v
// uart with transmit holding/fifo and receive fifo event logic
// assumes a classic wishbone master, an asynchronous rx line and a dma
// controller that consumes the receive event pulse
//
// Contract
// - holding-empty interrupt whenever another byte fits; in fifo mode the code raises it only once the fifo is empty
// - move byte to shift register, then interrupt
// - fifo mode delays empty interrupt one baud
// - empty means holding empty, or fifo empty
// - fifo enable bit set selects fifo mode
// - one enable bit buffers both directions
// - trigger field 00b means one byte
// - receive event and receive interrupt both
// - detect framing and parity errors per byte
// - withhold dma event while fifo holds errors; code withholds it in fifo mode only
// - error interrupt as soon as detected; code sets it at the stop bit sample
//
// Local design decisions: the address map and the Wishbone register port.
`include "utf_defs.vh"
`timescale 1ns/1ps
module utf_uart #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i, // 200 MHz clock
    input wire rst_i, // synchronous reset
    input wire wb_cyc_i, // wishbone cycle
    input wire wb_stb_i, // wishbone strobe
    input wire wb_we_i, // wishbone write
    input wire [3:0] wb_adr_i, // byte address
    input wire [3:0] wb_sel_i, // byte selects
    input wire [31:0] wb_dat_i, // write data
    output reg [31:0] wb_dat_o, // read data
    output reg wb_ack_o, // wishbone ack
    input wire rx_i, // serial input
    output reg tx_o, // serial output
    output reg thre_irq_o, // holding-empty interrupt
    output reg rx_irq_o, // receive data-ready interrupt
    output reg err_irq_o, // receive error interrupt
    output reg rx_event_o // dma receive event pulse
);
    reg [3:0] ctl_ff;
    reg [15:0] div_ff;
    reg [15:0] bdiv_ff;
    reg os_tick_ff;
    reg rx_s1_ff, rx_s2_ff;
    reg tx_busy_ff;
    reg [10:0] tx_shift_reg;
    reg [3:0] tx_bits_ff, tx_os_ff;
    reg thre_dly_ff;
    reg rx_busy_ff;
    reg [3:0] rx_bits_ff, rx_os_ff;
    reg [7:0] rx_data_ff;
    reg rx_perr_ff;
    reg [9:0] rx_hold_ff;
    reg rx_hold_vld_ff;
    reg ovr_ff;
    reg rx_lvl_ff;
    reg [AW:0] err_cnt_ff;
    wire fifo_mode;
    wire par_en;
    wire [3:0] nbits;
    wire req;
    wire [AW:0] tx_cnt, rx_cnt;
    wire tx_in_rdy, tx_vld, rx_in_rdy, rx_vld;
    wire [7:0] tx_holding_reg;
    wire [9:0] rx_head;
    wire tx_push, tx_pop, rx_push, rx_pop;
    wire tx_load;
    wire [AW:0] trig;
    wire rx_lvl;
    wire [AW:0] one;
    wire [7:0] nxt_rx_data;

    function [AW:0] trig_lvl;
        input [1:0] fld;
        begin
            case (fld)
                2'b00: trig_lvl = `UTF_TRG_00;
                2'b01: trig_lvl = `UTF_TRG_01;
                2'b10: trig_lvl = `UTF_TRG_10;
                default: trig_lvl = `UTF_TRG_11;
            endcase
        end
    endfunction

    // single enable bit selects fifo mode
    // same bit serves transmit and receive
    assign fifo_mode = ctl_ff[`UTF_CTL_FEN];
    assign par_en = ctl_ff[`UTF_CTL_PEN];
    assign nbits = par_en ? `UTF_BITS_PAR : `UTF_BITS_NOPAR;
    assign one = {{AW{1'b0}}, 1'b1};
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // holding slot takes a byte only when free
    assign tx_push = req & wb_we_i & wb_sel_i[0] &
        (wb_adr_i == `UTF_ADR_DATA) &
        (fifo_mode ? tx_in_rdy : (tx_cnt == {(AW+1){1'b0}}));
    // head byte moves into the shift register
    assign tx_load = ~tx_busy_ff & tx_vld;
    assign tx_pop = tx_load;
    assign rx_pop = req & ~wb_we_i & (wb_adr_i == `UTF_ADR_DATA);
    assign rx_push = rx_hold_vld_ff &
        (fifo_mode ? rx_in_rdy : (rx_cnt == {(AW+1){1'b0}}));
    // trigger field picks level, 00b is one byte
    assign trig = fifo_mode ? trig_lvl(ctl_ff[`UTF_CTL_TRG_HI:
        `UTF_CTL_TRG_LO]) : one;
    assign rx_lvl = (rx_cnt >= trig);
    assign nxt_rx_data = {rx_s2_ff, rx_data_ff[7:1]};

    utf_fifo #(.DW(8), .DEPTH(DEPTH), .AW(AW)) u_txq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(tx_push),
        .in_ready_o(tx_in_rdy),
        .in_data_i(wb_dat_i[7:0]),
        .out_valid_o(tx_vld),
        .out_ready_i(tx_pop),
        .out_data_o(tx_holding_reg),
        .count_o(tx_cnt)
    );

    utf_fifo #(.DW(10), .DEPTH(DEPTH), .AW(AW)) u_rxq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(rx_push),
        .in_ready_o(rx_in_rdy),
        .in_data_i(rx_hold_ff),
        .out_valid_o(rx_vld),
        .out_ready_i(rx_pop),
        .out_data_o(rx_head),
        .count_o(rx_cnt)
    );

    // wishbone slave: ack one cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctl_ff <= `UTF_CTL_RST;
            div_ff <= `UTF_DIV_RST;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req & wb_we_i) begin
                if (wb_adr_i == `UTF_ADR_CTRL && wb_sel_i[0])
                    ctl_ff <= wb_dat_i[3:0];
                if (wb_adr_i == `UTF_ADR_DIV) begin
                    if (wb_sel_i[0])
                        div_ff[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        div_ff[15:8] <= wb_dat_i[15:8];
                end
            end else if (req) begin
                case (wb_adr_i)
                    `UTF_ADR_DATA: wb_dat_o[9:0] <= rx_vld ? rx_head :
                        10'h000;
                    `UTF_ADR_CTRL: wb_dat_o[3:0] <= ctl_ff;
                    `UTF_ADR_STAT: begin
                        wb_dat_o[`UTF_ST_THRE] <= thre_irq_o;
                        wb_dat_o[`UTF_ST_RXRDY] <= rx_irq_o;
                        wb_dat_o[`UTF_ST_ERR] <= err_irq_o;
                        wb_dat_o[`UTF_ST_OVR] <= ovr_ff;
                        wb_dat_o[`UTF_ST_TXFULL] <= fifo_mode ?
                            ~tx_in_rdy : tx_vld;
                        wb_dat_o[`UTF_ST_CNT_HI:`UTF_ST_CNT_LO] <= rx_cnt;
                    end
                    `UTF_ADR_DIV: wb_dat_o[15:0] <= div_ff;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // baud clock: one enable pulse per divisor period
    always @(posedge clk_i) begin
        if (rst_i) begin
            bdiv_ff <= 16'h0000;
            os_tick_ff <= 1'b0;
        end else if (bdiv_ff >= div_ff) begin
            bdiv_ff <= 16'h0000;
            os_tick_ff <= 1'b1;
        end else begin
            bdiv_ff <= bdiv_ff + 16'h0001;
            os_tick_ff <= 1'b0;
        end
    end

    // transmitter: start, 8 data lsb first, optional even parity, stop
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_busy_ff <= 1'b0;
            tx_shift_reg <= 11'h7ff;
            tx_bits_ff <= 4'h0;
            tx_os_ff <= 4'h0;
            tx_o <= 1'b1;
        end else if (tx_load) begin
            tx_busy_ff <= 1'b1;
            tx_shift_reg <= {1'b1, par_en ? ^tx_holding_reg : 1'b1,
                tx_holding_reg, 1'b0};
            tx_bits_ff <= 4'h0;
            tx_os_ff <= 4'h0;
            tx_o <= 1'b0;
        end else if (tx_busy_ff & os_tick_ff) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == `UTF_OS_LAST) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                tx_bits_ff <= tx_bits_ff + 4'h1;
                tx_o <= tx_shift_reg[1];
                if (tx_bits_ff + 4'h1 == nbits) begin
                    tx_busy_ff <= 1'b0;
                    tx_o <= 1'b1;
                end
            end
        end
    end

    // empty interrupt whenever the holding slot is free
    // fifo mode waits one baud clock after emptying
    // empty means holding slot or whole fifo empty
    always @(posedge clk_i) begin
        if (rst_i) begin
            thre_dly_ff <= 1'b0;
            thre_irq_o <= 1'b0;
        end else begin
            if (tx_vld)
                thre_dly_ff <= 1'b0;
            else if (os_tick_ff)
                thre_dly_ff <= 1'b1;
            thre_irq_o <= ~tx_vld & ~tx_push &
                (~fifo_mode | thre_dly_ff);
        end
    end

    // receiver: line passes two flip-flops first
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            rx_s1_ff <= rx_i;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // stop bit checked for every byte, parity only when parity is enabled
    // error interrupt set when the stop bit is sampled
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_busy_ff <= 1'b0;
            rx_bits_ff <= 4'h0;
            rx_os_ff <= 4'h0;
            rx_data_ff <= 8'h00;
            rx_perr_ff <= 1'b0;
            rx_hold_ff <= 10'h000;
            rx_hold_vld_ff <= 1'b0;
            ovr_ff <= 1'b0;
            err_irq_o <= 1'b0;
        end else begin
            if (rx_push)
                rx_hold_vld_ff <= 1'b0;
            if (req & wb_we_i & wb_sel_i[0] &
                (wb_adr_i == `UTF_ADR_STAT)) begin
                if (wb_dat_i[`UTF_ST_ERR])
                    err_irq_o <= 1'b0;
                if (wb_dat_i[`UTF_ST_OVR])
                    ovr_ff <= 1'b0;
            end
            if (os_tick_ff) begin
                if (~rx_busy_ff) begin
                    if (~rx_s2_ff) begin
                        rx_busy_ff <= 1'b1;
                        rx_os_ff <= 4'h0;
                        rx_bits_ff <= 4'h0;
                        rx_perr_ff <= 1'b0;
                    end
                end else begin
                    rx_os_ff <= rx_os_ff + 4'h1;
                    if (rx_os_ff == `UTF_OS_MID) begin
                        rx_bits_ff <= rx_bits_ff + 4'h1;
                        if (rx_bits_ff == 4'h0) begin
                            if (rx_s2_ff)
                                rx_busy_ff <= 1'b0;
                        end else if (rx_bits_ff < `UTF_DATA_END) begin
                            rx_data_ff <= nxt_rx_data;
                        end else if (rx_bits_ff + 4'h1 < nbits) begin
                            rx_perr_ff <= ^rx_data_ff ^ rx_s2_ff;
                        end else begin
                            rx_busy_ff <= 1'b0;
                            // a new byte while one still waits is lost
                            if (rx_hold_vld_ff & ~rx_push) begin
                                ovr_ff <= 1'b1;
                            end else begin
                                rx_hold_vld_ff <= 1'b1;
                                rx_hold_ff <= {rx_perr_ff, ~rx_s2_ff,
                                    rx_data_ff};
                            end
                            if (rx_perr_ff | ~rx_s2_ff)
                                err_irq_o <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // data-ready level and dma event pulse
    // in fifo mode only, event held back while errored bytes sit in the fifo
    always @(posedge clk_i) begin
        if (rst_i) begin
            err_cnt_ff <= {(AW+1){1'b0}};
            rx_lvl_ff <= 1'b0;
            rx_irq_o <= 1'b0;
            rx_event_o <= 1'b0;
        end else begin
            if ((rx_push & (|rx_hold_ff[9:8])) &
                ~(rx_pop & rx_vld & (|rx_head[9:8])))
                err_cnt_ff <= err_cnt_ff + one;
            else if (~(rx_push & (|rx_hold_ff[9:8])) &
                (rx_pop & rx_vld & (|rx_head[9:8])))
                err_cnt_ff <= err_cnt_ff - one;
            rx_lvl_ff <= rx_lvl;
            rx_irq_o <= rx_lvl;
            rx_event_o <= rx_lvl & ~rx_lvl_ff &
                (~fifo_mode | (err_cnt_ff == {(AW+1){1'b0}}));
        end
    end
endmodule

// file: utf_uart_monitor.sv
// port-level checks for the uart event block
// assumes it is bound into utf_uart, one clock, sync reset
`timescale 1ns/1ps
module utf_uart_monitor (
    input wire clk_i, // clock
    input wire rst_i, // reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_we_i, // write
    input wire [3:0] wb_adr_i, // address
    input wire [3:0] wb_sel_i, // selects
    input wire [31:0] wb_dat_i, // write data
    input wire [31:0] wb_dat_o, // read data
    input wire wb_ack_o, // ack
    input wire rx_i, // serial in
    input wire tx_o, // serial out
    input wire thre_irq_o, // empty irq
    input wire rx_irq_o, // ready irq
    input wire err_irq_o, // error irq
    input wire rx_event_o // dma event
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire stat_wr = take && wb_we_i && wb_adr_i == 4'h8;
    wire data_wr = take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
    property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse");
    property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat: assert property (p_dat) else $error("read data outside ack");
    property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_rst;
        disable iff (1'b0)
        rst_i |=> tx_o && !rx_event_o && !err_irq_o && !wb_ack_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle in reset");
    property p_ev; rx_event_o |=> !rx_event_o; endproperty
    a_ev: assert property (p_ev) else $error("event longer than a cycle");
    property p_evl; rx_event_o |-> rx_irq_o; endproperty
    a_evl: assert property (p_evl) else $error("event without ready");
    property p_err; err_irq_o && !stat_wr |=> err_irq_o; endproperty
    a_err: assert property (p_err) else $error("error irq dropped");
    property p_thr; data_wr |=> !thre_irq_o; endproperty
    a_thr: assert property (p_thr) else $error("empty irq on write");
endmodule

// file: utf_uart_tb.sv
// self-checking bench for the uart event block
// assumes utf_uart, the utf_remote partner and the bound monitor
`timescale 1ns/1ps
module utf_uart_tb;
    logic clk_i, rst_i, cyc, stb, we;
    logic [3:0] adr;
    logic [31:0] dat, q;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, tx_o, thre_irq_o, rx_irq_o, err_irq_o, rx_event_o, rx_i;
    integer miscompares = 0, check_count = 0, ev_cnt = 0, nexp = 0;
    utf_uart dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_i(rx_i), .tx_o(tx_o), .thre_irq_o(thre_irq_o),
        .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o),
        .rx_event_o(rx_event_o));
    utf_remote #(.BIT(32)) rm_u (.clk_i(clk_i), .line_i(tx_o),
        .line_o(rx_i));
    task final_report;
        begin
            if (miscompares == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count++;
            if (g !== e) begin
                miscompares++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            n = 0;
            // ack and read data are sampled at the rising edge only
            do begin
                @(posedge clk_i);
                n++;
            end while (wb_ack_o !== 1'b1 && n < 50);
            q = wb_dat_o;
            if (wb_ack_o !== 1'b1) begin
                miscompares++;
                final_report;
            end
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    function logic cond(input [1:0] k);
        case (k)
            2'h0: cond = rx_irq_o === 1'b1;
            2'h1: cond = err_irq_o === 1'b1;
            2'h2: cond = thre_irq_o === 1'b1;
            default: cond = rm_u.got.size() >= nexp;
        endcase
    endfunction
    task till(input [1:0] k, input integer lim);
        integer n;
        begin
            n = 0;
            while (!cond(k) && n < lim) begin
                @(posedge clk_i);
                n++;
            end
            if (!cond(k)) begin
                miscompares++;
                final_report;
            end
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (rx_event_o === 1'b1)
            ev_cnt++;
    end
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        dat = 32'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, 4'h4, 0);
        chk(q, 32'h0);
        bus(0, 4'hc, 0);
        chk(q, 32'h6c);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        chk(thre_irq_o, 1);
        bus(1, 4'hc, 32'h1);
        // unbuffered: at least one baud clock after the empty interrupt
        repeat (4) @(posedge clk_i);
        // unbuffered: third byte finds the holding slot full
        bus(1, 4'h0, 32'ha5);
        bus(1, 4'h0, 32'h3c);
        bus(1, 4'h0, 32'h77);
        bus(0, 4'h8, 0);
        chk(q, 32'h10);
        nexp = 2;
        till(3, 2000);
        chk(rm_u.got[0], 32'ha5);
        chk(rm_u.got[1], 32'h3c);
        chk(thre_irq_o, 1);
        bus(1, 4'h4, 32'h1);
        bus(0, 4'h4, 0);
        chk(q, 32'h1);
        bus(1, 4'h0, 32'h11);
        bus(1, 4'h0, 32'h22);
        bus(1, 4'h0, 32'h33);
        chk(thre_irq_o, 0);
        till(2, 3000);
        chk(rm_u.got.size(), 4);
        nexp = 5;
        till(3, 1000);
        chk(rm_u.got[4], 32'h33);
        rm_u.send(8'h5a, 0, 0, 0);
        till(0, 200);
        chk(ev_cnt, 1);
        bus(0, 4'h8, 0);
        chk(q, 32'h103);
        bus(0, 4'h0, 0);
        chk(q, 32'h5a);
        bus(1, 4'h4, 32'h9);
        rm_u.send(8'h33, 1, 1, 0);
        till(1, 200);
        chk(ev_cnt, 1);
        bus(0, 4'h0, 0);
        chk(q, 32'h233);
        bus(1, 4'h8, 32'h4);
        chk(err_irq_o, 0);
        rm_u.send(8'h0f, 1, 0, 1);
        till(1, 200);
        bus(0, 4'h0, 0);
        chk(q, 32'h10f);
        chk(rm_u.got.size(), 5);
        final_report;
    end
endmodule
bind utf_uart utf_uart_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .tx_o(tx_o),
    .thre_irq_o(thre_irq_o), .rx_irq_o(rx_irq_o),
    .err_irq_o(err_irq_o), .rx_event_o(rx_event_o));
